// File: common/rwg_pkg.sv
package rwg_pkg;
    // Register byte offsets
    localparam logic [7:0] RWG_OFF_CFG = 8'h00;
    localparam logic [7:0] RWG_OFF_KEY = 8'h04;
    localparam logic [7:0] RWG_OFF_OSC = 8'h08;
    localparam logic [7:0] RWG_OFF_TIME = 8'h0C;
    localparam logic [7:0] RWG_OFF_DATE = 8'h10;
    // Field positions
    localparam int RWG_BIT_WREN = 13;
    localparam int RWG_BIT_EN = 15;
    localparam int RWG_BIT_OSCEN = 1;
    // Key values
    localparam logic [7:0] RWG_KEY_FIRST = 8'h55;
    localparam logic [7:0] RWG_KEY_SECOND = 8'hAA;
    // Reset values
    localparam logic [31:0] RWG_RST_TIME = 32'h00000000;
    localparam logic [31:0] RWG_RST_DATE = 32'h00000000;
    // AXI responses
    localparam logic [1:0] RWG_RESP_OKAY = 2'h0;
    localparam logic [1:0] RWG_RESP_SLVERR = 2'h2;
    // Unlock tracker states
    typedef enum logic [1:0] {RWG_KEY_IDLE, RWG_KEY_GOT55, RWG_KEY_ARMED} rwg_key_t;
endpackage

// File: dv/rwg_top_test.sv
`timescale 1ns/1ps
// Self-checking bench for the write-protection guard, AXI4-Lite master side
module rwg_top_test;
    localparam logic [7:0] A_CFG = rwg_pkg::RWG_OFF_CFG;
    localparam logic [7:0] A_KEY = rwg_pkg::RWG_OFF_KEY;
    localparam logic [7:0] A_OSC = rwg_pkg::RWG_OFF_OSC;
    localparam logic [7:0] A_TIME = rwg_pkg::RWG_OFF_TIME;
    localparam logic [7:0] A_DATE = rwg_pkg::RWG_OFF_DATE;
    localparam logic [31:0] M_CFG = 32'h0000A000;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic module_run_out;
    logic osc_sel_out;
    logic [31:0] time_out;
    logic [31:0] date_out;
    int n_errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000B46D;

    rwg_top #(.ADDR_W(8)) rwg_top_inst (.clock_in(clock_in), .rst_in(rst_in),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .module_run_out(module_run_out), .osc_sel_out(osc_sel_out),
        .time_out(time_out), .date_out(date_out));

    // 200 MHz clock
    initial begin
        forever #2.5 clock_in = ~clock_in;
    end

    // Hang guard: a whole run needs about 300 cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_errors++;
            give_verdict();
        end
    end

    // Xorshift source, fixed seed keeps runs repeatable
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected configuration word from the two guarded bits
    function automatic logic [31:0] cfg(input logic en, input logic wren);
        logic [31:0] w;
        w = 32'h00000000;
        w[rwg_pkg::RWG_BIT_EN] = en;
        w[rwg_pkg::RWG_BIT_WREN] = wren;
        return w;
    endfunction

    task automatic give_verdict();
        $display("errors %0d, comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected data at %0t: got %08h expected %08h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected response at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each held until its own ready
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw_open || w_open) begin
            @(posedge clock_in);
            if (aw_open && s_axi_awready === 1'b1) begin
                aw_open = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_open && s_axi_wready === 1'b1) begin
                w_open = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge clock_in); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock_in); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge clock_in); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, 4'hF, r);
        chk_resp(r, rwg_pkg::RWG_RESP_OKAY);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk_resp(r, rwg_pkg::RWG_RESP_OKAY);
        chk(d & m, e);
    endtask

    task automatic key(input logic [7:0] k);
        wr(A_KEY, {24'h000000, k});
    endtask

    initial begin
        logic [31:0] v;
        logic [31:0] t_exp;
        logic [31:0] d;
        logic [1:0] r;
        t_exp = rwg_pkg::RWG_RST_TIME;
        repeat (2) @(posedge clock_in);
        rst_in <= 1'b0;
        @(posedge clock_in);
        // Reset state: everything clear
        rd(A_CFG, M_CFG, cfg(1'b0, 1'b0));
        chk({31'h0, module_run_out}, 32'h00000000);
        rd(A_TIME, 32'hFFFFFFFF, t_exp);
        // Locked time write completes with OKAY but changes nothing
        wr(A_TIME, next_rand());
        chk(time_out, t_exp);
        // Setting both bits with no key is ignored
        wr(A_CFG, cfg(1'b1, 1'b1));
        rd(A_CFG, M_CFG, cfg(1'b0, 1'b0));
        // Wrong second key, then a foreign write between key and set
        key(rwg_pkg::RWG_KEY_FIRST);
        key(8'h12);
        key(rwg_pkg::RWG_KEY_SECOND);
        wr(A_CFG, cfg(1'b0, 1'b1));
        rd(A_CFG, M_CFG, cfg(1'b0, 1'b0));
        key(rwg_pkg::RWG_KEY_FIRST);
        key(rwg_pkg::RWG_KEY_SECOND);
        wr(A_OSC, 32'h00000000);
        wr(A_CFG, cfg(1'b0, 1'b1));
        rd(A_CFG, M_CFG, cfg(1'b0, 1'b0));
        // Repeated first key restarts; a read in between does not disturb
        key(rwg_pkg::RWG_KEY_FIRST);
        key(rwg_pkg::RWG_KEY_FIRST);
        rd(A_KEY, 32'hFFFFFFFF, 32'h00000000);
        key(rwg_pkg::RWG_KEY_SECOND);
        wr(A_CFG, cfg(1'b0, 1'b1));
        rd(A_CFG, M_CFG, cfg(1'b0, 1'b1));
        // Enable while unlocked, then stop it before correcting the time
        wr(A_CFG, cfg(1'b1, 1'b1));
        chk({31'h0, module_run_out}, 32'h00000001);
        wr(A_CFG, cfg(1'b0, 1'b1));
        chk({31'h0, module_run_out}, 32'h00000000);
        v = next_rand();
        wr(A_DATE, v);
        chk(date_out, v);
        // Byte 0 only: upper bytes of the time word kept
        t_exp = ~v;
        wr(A_TIME, t_exp);
        axi_wr(A_TIME, v, 4'h1, r);
        chk_resp(r, rwg_pkg::RWG_RESP_OKAY);
        t_exp = {t_exp[31:8], v[7:0]};
        chk(time_out, t_exp);
        // Clear write enable while setting the module enable, no key needed
        wr(A_CFG, cfg(1'b1, 1'b0));
        rd(A_CFG, M_CFG, cfg(1'b1, 1'b0));
        wr(A_CFG, cfg(1'b0, 1'b0));
        chk({31'h0, module_run_out}, 32'h00000001);
        // Oscillator select bit
        wr(A_OSC, 32'h00000002);
        chk({31'h0, osc_sel_out}, 32'h00000001);
        rd(A_OSC, 32'h00000002, 32'h00000002);
        // Unmapped offset refused on both channels
        axi_wr(8'h20, 32'hFFFFFFFF, 4'hF, r);
        chk_resp(r, rwg_pkg::RWG_RESP_SLVERR);
        axi_rd(8'h20, d, r);
        chk_resp(r, rwg_pkg::RWG_RESP_SLVERR);
        chk(d, 32'h00000000);
        // Random lock state against random time words
        for (int i = 0; i < 24; i++) begin
            v = next_rand();
            if (v[0]) begin
                key(rwg_pkg::RWG_KEY_FIRST);
                key(rwg_pkg::RWG_KEY_SECOND);
                wr(A_CFG, cfg(1'b1, 1'b1));
                t_exp = v;
            end else begin
                wr(A_CFG, cfg(1'b1, 1'b0));
            end
            wr(A_TIME, v);
            chk(time_out, t_exp);
        end
        give_verdict();
    end
endmodule

// File: rtl/rwg_top.sv
`timescale 1ns/1ps
// Write-protection guard for the calendar clock unit, AXI4-Lite slave
module rwg_top #(
    parameter int ADDR_W = 8 // Address width
) (
    input wire logic clock_in, // 200 MHz system clock
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic module_run_out, // Clock module enabled
    output logic osc_sel_out, // Secondary oscillator enabled
    output logic [31:0] time_out, // Time register contents
    output logic [31:0] date_out // Calendar register contents
);
    // Offsets reach 0x10, so fewer than five address bits cannot decode them
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must be 5..32");
    end

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wren;
        logic en;
        logic oscen;
        logic [31:0] time_reg;
        logic [31:0] date_reg;
    } rwg_state_t;

    rwg_state_t cur;
    rwg_state_t next_cur;
    logic wr_fire;
    logic key_wr;
    logic armed;
    logic [7:0] waddr8;
    logic [7:0] raddr8;

    // Low address byte selects the register; upper bits must be zero
    assign waddr8 = 8'(cur.awaddr);
    assign raddr8 = 8'(s_axi_araddr);
    assign wr_fire = cur.aw_held && cur.w_held && !cur.bvalid;
    assign key_wr = wr_fire && waddr8 == rwg_pkg::RWG_OFF_KEY && cur.wstrb[0]
        && (cur.awaddr >> 8) == '0;

    rwg_unlock rwg_unlock_inst (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .wr_in(wr_fire),
        .key_wr_in(key_wr),
        .key_in(cur.wdata[7:0]),
        .armed_out(armed)
    );

    // Apply byte strobes to an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus handshakes and register effects
    always_comb begin
        logic hi_ok;
        logic [31:0] cfgw;
        hi_ok = 1'b0;
        cfgw = 32'h00000000;
        next_cur = cur;
        // Write address and data captured independently, either order
        if (s_axi_awvalid && cur.awready) begin
            next_cur.awaddr = s_axi_awaddr;
            next_cur.aw_held = 1'b1;
            next_cur.awready = 1'b0;
        end
        if (s_axi_wvalid && cur.wready) begin
            next_cur.wdata = s_axi_wdata;
            next_cur.wstrb = s_axi_wstrb;
            next_cur.w_held = 1'b1;
            next_cur.wready = 1'b0;
        end
        if (wr_fire) begin
            hi_ok = (cur.awaddr >> 8) == '0;
            next_cur.bvalid = 1'b1;
            next_cur.bresp = rwg_pkg::RWG_RESP_OKAY;
            next_cur.aw_held = 1'b0;
            next_cur.w_held = 1'b0;
            if (!hi_ok) begin
                next_cur.bresp = rwg_pkg::RWG_RESP_SLVERR;
            end else begin
                unique case (waddr8)
                    rwg_pkg::RWG_OFF_CFG: begin
                        cfgw = merge({16'h0000, cur.en, 1'b0, cur.wren, 13'h0000},
                                     cur.wdata, cur.wstrb);
                        // Set needs the key; clear always accepted
                        if (!cfgw[rwg_pkg::RWG_BIT_WREN]) begin
                            next_cur.wren = 1'b0;
                        end else if (armed) begin
                            next_cur.wren = 1'b1;
                        end
                        // Enable moves only with write enable already set
                        if (cur.wren) begin
                            next_cur.en = cfgw[rwg_pkg::RWG_BIT_EN];
                        end
                    end
                    rwg_pkg::RWG_OFF_KEY: begin
                        next_cur.bresp = rwg_pkg::RWG_RESP_OKAY;
                    end
                    rwg_pkg::RWG_OFF_OSC: begin
                        cfgw = merge({30'h00000000, cur.oscen, 1'b0}, cur.wdata, cur.wstrb);
                        next_cur.oscen = cfgw[rwg_pkg::RWG_BIT_OSCEN];
                    end
                    rwg_pkg::RWG_OFF_TIME: begin
                        // Blocked writes still answer OKAY
                        if (cur.wren) begin
                            next_cur.time_reg = merge(cur.time_reg, cur.wdata,
                                                      cur.wstrb);
                        end
                    end
                    rwg_pkg::RWG_OFF_DATE: begin
                        if (cur.wren) begin
                            next_cur.date_reg = merge(cur.date_reg, cur.wdata,
                                                      cur.wstrb);
                        end
                    end
                    default: begin
                        next_cur.bresp = rwg_pkg::RWG_RESP_SLVERR;
                    end
                endcase
            end
        end
        if (cur.bvalid && s_axi_bready) begin
            next_cur.bvalid = 1'b0;
            next_cur.awready = 1'b1;
            next_cur.wready = 1'b1;
        end
        // Read channel, one outstanding
        if (s_axi_arvalid && cur.arready) begin
            next_cur.arready = 1'b0;
            next_cur.rvalid = 1'b1;
            next_cur.rresp = rwg_pkg::RWG_RESP_OKAY;
            next_cur.rdata = 32'h00000000;
            if ((s_axi_araddr >> 8) != '0) begin
                next_cur.rresp = rwg_pkg::RWG_RESP_SLVERR;
            end else begin
                unique case (raddr8)
                    rwg_pkg::RWG_OFF_CFG: begin
                        next_cur.rdata[rwg_pkg::RWG_BIT_EN] = cur.en;
                        next_cur.rdata[rwg_pkg::RWG_BIT_WREN] = cur.wren;
                    end
                    rwg_pkg::RWG_OFF_KEY: begin
                        next_cur.rdata = 32'h00000000; // Key reads back as zero
                    end
                    rwg_pkg::RWG_OFF_OSC: begin
                        next_cur.rdata[rwg_pkg::RWG_BIT_OSCEN] = cur.oscen;
                    end
                    rwg_pkg::RWG_OFF_TIME: begin
                        next_cur.rdata = cur.time_reg;
                    end
                    rwg_pkg::RWG_OFF_DATE: begin
                        next_cur.rdata = cur.date_reg;
                    end
                    default: begin
                        next_cur.rresp = rwg_pkg::RWG_RESP_SLVERR;
                    end
                endcase
            end
        end
        if (cur.rvalid && s_axi_rready) begin
            next_cur.rvalid = 1'b0;
            next_cur.arready = 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur <= '0;
            cur.awready <= 1'b1;
            cur.wready <= 1'b1;
            cur.arready <= 1'b1;
            cur.time_reg <= rwg_pkg::RWG_RST_TIME;
            cur.date_reg <= rwg_pkg::RWG_RST_DATE;
        end else begin
            cur <= next_cur;
        end
    end

    // Outputs straight from state flops
    assign s_axi_awready = cur.awready;
    assign s_axi_wready = cur.wready;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = cur.arready;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
    assign module_run_out = cur.en;
    assign osc_sel_out = cur.oscen;
    assign time_out = cur.time_reg;
    assign date_out = cur.date_reg;

    // Decoded writes for the guard assertions; high address bits must be clear
    logic cfg_hit;
    logic time_hit;
    logic date_hit;
    assign cfg_hit = wr_fire && waddr8 == rwg_pkg::RWG_OFF_CFG && (cur.awaddr >> 8) == '0;
    assign time_hit = wr_fire && waddr8 == rwg_pkg::RWG_OFF_TIME && (cur.awaddr >> 8) == '0;
    assign date_hit = wr_fire && waddr8 == rwg_pkg::RWG_OFF_DATE && (cur.awaddr >> 8) == '0;

    // Lock guards: contents and enable frozen while write enable is clear
    a_time_locked: assert property (@(posedge clock_in) disable iff (rst_in)
        !cur.wren |=> $stable(cur.time_reg) && $stable(cur.date_reg))
        else $error("time changed while locked");
    a_blocked_resp: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_fire && waddr8 == rwg_pkg::RWG_OFF_TIME && (cur.awaddr >> 8) == '0)
        |=> s_axi_bvalid && s_axi_bresp == rwg_pkg::RWG_RESP_OKAY)
        else $error("time write not answered OKAY");
    a_wren_set_key: assert property (@(posedge clock_in) disable iff (rst_in)
        $rose(cur.wren) |-> $past(armed) && $past(wr_fire))
        else $error("write enable set without key");
    a_wren_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_fire && waddr8 == rwg_pkg::RWG_OFF_CFG && (cur.awaddr >> 8) == '0
         && cur.wstrb[1] && !cur.wdata[rwg_pkg::RWG_BIT_WREN]) |=> !cur.wren)
        else $error("write enable clear refused");
    a_en_locked: assert property (@(posedge clock_in) disable iff (rst_in)
        !cur.wren |=> $stable(cur.en))
        else $error("enable changed while locked");
    a_run_follows: assert property (@(posedge clock_in) disable iff (rst_in)
        $changed(module_run_out) |-> $past(cfg_hit) && $past(cur.wren))
        else $error("run output moved without an unlocked config write");
    a_wren_pos: assert property (@(posedge clock_in) disable iff (rst_in)
        (s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready
         && s_axi_araddr == ADDR_W'(rwg_pkg::RWG_OFF_CFG)))
        |-> s_axi_rdata[rwg_pkg::RWG_BIT_WREN] == $past(cur.wren))
        else $error("write enable misplaced in readback");
    a_bvalid_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");

    // Unlocked writes land, and bus answers stand until taken
    a_en_write: assert property (@(posedge clock_in) disable iff (rst_in)
        (cfg_hit && cur.wren && cur.wstrb[1])
        |=> cur.en == $past(cur.wdata[rwg_pkg::RWG_BIT_EN]))
        else $error("enable not taken while unlocked");
    a_key_okay: assert property (@(posedge clock_in) disable iff (rst_in)
        (wr_fire && waddr8 == rwg_pkg::RWG_OFF_KEY && (cur.awaddr >> 8) == '0)
        |=> s_axi_bresp == rwg_pkg::RWG_RESP_OKAY)
        else $error("key write not answered OKAY");
    a_time_open: assert property (@(posedge clock_in) disable iff (rst_in)
        (time_hit && cur.wren && cur.wstrb == 4'hF)
        |=> cur.time_reg == $past(cur.wdata))
        else $error("unlocked time write lost");
    a_date_open: assert property (@(posedge clock_in) disable iff (rst_in)
        (date_hit && cur.wren && cur.wstrb == 4'hF)
        |=> cur.date_reg == $past(cur.wdata))
        else $error("unlocked date write lost");
    a_wren_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (cur.wren && !cfg_hit) |=> cur.wren)
        else $error("write enable dropped without a config write");
    a_rvalid_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    // Main scenarios the bench should reach

    c_unlock: cover property (@(posedge clock_in) disable iff (rst_in) $rose(cur.wren));
    c_enable: cover property (@(posedge clock_in) disable iff (rst_in) $rose(cur.en));
    c_time_wr: cover property (@(posedge clock_in) disable iff (rst_in)
        cur.wren && wr_fire && waddr8 == rwg_pkg::RWG_OFF_TIME);
    c_blocked: cover property (@(posedge clock_in) disable iff (rst_in)
        !cur.wren && wr_fire && waddr8 == rwg_pkg::RWG_OFF_TIME);
    c_refused_set: cover property (@(posedge clock_in) disable iff (rst_in)
        cfg_hit && !armed && !cur.wren && cur.wdata[rwg_pkg::RWG_BIT_WREN]);
endmodule

// File: rtl/rwg_unlock.sv
`timescale 1ns/1ps
// Key sequence tracker: arms for exactly one following write
module rwg_unlock (
    input wire logic clock_in, // System clock
    input wire logic rst_in, // Synchronous reset
    input wire logic wr_in, // One-cycle pulse per register write
    input wire logic key_wr_in, // This write targets the key register
    input wire logic [7:0] key_in, // Written key byte
    output logic armed_out // Next write may set write enable
);
    typedef struct packed {
        rwg_pkg::rwg_key_t st;
    } rwg_ul_state_t;
    rwg_ul_state_t cur;
    rwg_ul_state_t next_cur;

    // Any write that is not the expected step drops the sequence, or restarts it if it carries the first key
    always_comb begin
        next_cur = cur;
        if (wr_in) begin
            unique case (cur.st)
                rwg_pkg::RWG_KEY_IDLE: begin
                    next_cur.st = (key_wr_in && key_in == rwg_pkg::RWG_KEY_FIRST)
                        ? rwg_pkg::RWG_KEY_GOT55 : rwg_pkg::RWG_KEY_IDLE;
                end
                rwg_pkg::RWG_KEY_GOT55: begin
                    if (key_wr_in && key_in == rwg_pkg::RWG_KEY_SECOND) begin
                        next_cur.st = rwg_pkg::RWG_KEY_ARMED;
                    end else if (key_wr_in && key_in == rwg_pkg::RWG_KEY_FIRST) begin
                        next_cur.st = rwg_pkg::RWG_KEY_GOT55;
                    end else begin
                        next_cur.st = rwg_pkg::RWG_KEY_IDLE;
                    end
                end
                default: begin
                    // Armed lasts one write only, whatever it is
                    next_cur.st = (key_wr_in && key_in == rwg_pkg::RWG_KEY_FIRST)
                        ? rwg_pkg::RWG_KEY_GOT55 : rwg_pkg::RWG_KEY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            cur <= '{st: rwg_pkg::RWG_KEY_IDLE};
        end else begin
            cur <= next_cur;
        end
    end

    assign armed_out = (cur.st == rwg_pkg::RWG_KEY_ARMED);

    a_arm_needs_key: assert property (@(posedge clock_in) disable iff (rst_in)
        (cur.st != rwg_pkg::RWG_KEY_ARMED) |=> (cur.st == rwg_pkg::RWG_KEY_ARMED) |->
        $past(key_wr_in && wr_in && key_in == rwg_pkg::RWG_KEY_SECOND))
        else $error("armed without second key");
    a_arm_one_shot: assert property (@(posedge clock_in) disable iff (rst_in)
        (armed_out && wr_in) |=> !armed_out)
        else $error("armed state outlived one write");
endmodule
